// >>> shared/smbus_access_cfg.svh
// Constants for the SMBus configuration and EEPROM access block.
// Assumes a 25 MHz core clock and a separate oversampling link clock.
// Function
// - Write byte with command 00h-45h stores data into that register.
// - Commands 80h, 81h, 82h preset the EEPROM pointer low byte instead.
// - With 80h the low byte must be 00h-45h, else NACK that byte.
// - Write word: command is address high, then low byte, then data programmed.
// - Block write uses 83h and starts at the preset pointer.
// - Block write into registers saturates the pointer at 45h.
// - Block write advances the pointer after each accepted byte.
// - Receive byte returns data at pointer, then increments the pointer.
// - Block read: 84h, repeated start, read address, count 10h, 16 bytes.
// - Master may end a block read early; device releases the data line.
// - Block read command is acknowledged only when not busy.
// - Register pointers outside 00h-45h are answered with NACK.
// - Configuration EEPROM 8000h-8045h valid, 8046h-80FFh answered with NACK.
// - Block write into configuration EEPROM saturates at 8045h.
// - User EEPROM pages wrap to their own start in block transfers.
// - At supply good or reboot, wait 5us, then copy EEPROM at 1MHz.
// - Load ends within 3.5ms; serial access is blocked meanwhile.
// - Configuration EEPROM writes are refused while the lock bit is set.
// - One EEPROM byte write cycle lasts at most 11ms.
// - Register writes act at once and leave the EEPROM untouched.
// - Slave address is NACKed during reboot or EEPROM write cycle.
// - Address is 1010, two select pins, a don't care, then R/W.
// - Send byte 88h reboots; send byte 84h announces a block read.
`ifndef SMBUS_ACCESS_CFG_SVH
`define SMBUS_ACCESS_CFG_SVH
`define SLV_ID        4'ha
`define REG_LAST      8'h45
`define PTR_REG_LAST  16'h0045
`define PTR_EE_LAST   16'h8045
`define CMD_EE_CFG    8'h80
`define CMD_EE_U0     8'h81
`define CMD_EE_U1     8'h82
`define CMD_BLK_WR    8'h83
`define CMD_BLK_RD    8'h84
`define CMD_REBOOT    8'h88
`define BLK_RD_COUNT  8'h10
`define BLK_MAX       8'h10
`define CFG_BYTES     7'h46
`define USER_BYTES    10'h200
`define LOCK_REG      7'h45
`define LOCK_BIT      3'h0
`define CLK_MHZ       25
`define LOAD_DLY_US   5
`define LOAD_CLK_MHZ  1
`define LOAD_MAX_US   3500
`define EE_WR_US      11000
`define LOAD_DLY_CYC  (`LOAD_DLY_US * `CLK_MHZ)
`define LOAD_DIV_CYC  (`CLK_MHZ / `LOAD_CLK_MHZ)
`define LOAD_MAX_CYC  (`LOAD_MAX_US * `CLK_MHZ)
`define EE_WR_CYC     (`EE_WR_US * `CLK_MHZ)
`endif

// >>> shared/smbus_access_pkg.sv
// Types shared by the SMBus access block.
// Assumes nothing of its surroundings.
package smbus_access_pkg;
  typedef enum logic [3:0] {
    L_IDLE  = 4'h0,
    L_ADDR  = 4'h1,
    L_CMD   = 4'h2,
    L_DATA1 = 4'h3,
    L_DATA2 = 4'h4,
    L_BCNT  = 4'h5,
    L_BDATA = 4'h6,
    L_TX    = 4'h7,
    L_NACK  = 4'h8
  } link_st_t;
  typedef enum logic [1:0] {
    C_IDLE  = 2'h0,
    C_DELAY = 2'h1,
    C_COPY  = 2'h2
  } load_st_t;
  typedef struct packed {
    logic        we;
    logic [15:0] addr;
    logic [7:0]  data;
  } mem_req_t;
endpackage : smbus_access_pkg

// >>> rtl/smbus_config_eeprom_access.sv
// SMBus slave with configuration register bank, configuration and user EEPROM.
// Assumes open-drain bus lines resolved outside and an oversampling link clock.
`timescale 1ns/100ps
`include "smbus_access_cfg.svh"
module smbus_config_eeprom_access
  import smbus_access_pkg::*;
#(
  parameter int EE_WR_CYC    = `EE_WR_CYC,
  parameter int LOAD_MAX_CYC = `LOAD_MAX_CYC
) (
  input  wire logic                     clk_i,
  input  wire logic                     rst_n_i,
  input  wire logic                     link_clk_i,
  input  wire logic                     scl_i,
  input  wire logic                     sda_i,
  output logic                          sda_o,
  output logic                          sda_oe_n_o,
  input  wire logic                     addr_select_low_i,
  input  wire logic                     addr_select_high_i,
  input  wire logic                     supply_ok_i,
  output logic                          busy_o,
  output logic [`CFG_BYTES*8-1:0]       cfg_bank_o
);
  localparam int DLY_A = `LOAD_DLY_CYC;

  if (EE_WR_CYC < 1 || EE_WR_CYC >= 2**20 || `LOAD_DLY_CYC > 256 ||
      `LOAD_DLY_CYC + `CFG_BYTES * `LOAD_DIV_CYC > LOAD_MAX_CYC) begin : g_bad
    $error("Timing parameters out of range.");
  end
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Block pointer step: saturate at the last configuration byte, wrap in page.
  function automatic logic [15:0] blk_next(input logic [15:0] p);
    if (p == `PTR_REG_LAST || p == `PTR_EE_LAST) return p;
    if (p[15:8] == `CMD_EE_U0 || p[15:8] == `CMD_EE_U1) return {p[15:8], p[7:0] + 8'h01};
    return p + 16'h0001;
  endfunction : blk_next
  // User EEPROM index: page bit comes from the high address byte.
  function automatic logic [8:0] uidx(input logic [15:0] a);
    return {a[9], a[7:0]};
  endfunction : uidx
  // ----------------------------------------------------------------
  // Link domain: synchronisers and edge detection
  // ----------------------------------------------------------------
  logic [1:0]  lrst_s;
  logic        lrst_n;
  logic [1:0]  scl_s, sda_s, sel0_s, sel1_s, busy_s, lock_s, ack_s;
  logic        scl_d, sda_d;
  logic        busy, lock_bit, ack_tog;
  logic [7:0]  rd_data;
  // Reset enters the link domain through its own pair of flip-flops.
  always_ff @(posedge link_clk_i) begin
    lrst_s <= {lrst_s[0], rst_n_i};
  end
  assign lrst_n = lrst_s[1];
  // Every outside level passes two flip-flops before use.
  always_ff @(posedge link_clk_i) begin
    scl_s  <= {scl_s[0], scl_i};
    sda_s  <= {sda_s[0], sda_i};
    sel0_s <= {sel0_s[0], addr_select_low_i};
    sel1_s <= {sel1_s[0], addr_select_high_i};
    busy_s <= {busy_s[0], busy};
    lock_s <= {lock_s[0], lock_bit};
    ack_s  <= {ack_s[0], ack_tog};
    scl_d  <= scl_s[1];
    sda_d  <= sda_s[1];
  end
  // Start and stop are data edges while the clock stays high.
  logic scl_rise, scl_fall, start_ev, stop_ev;
  assign scl_rise = scl_s[1] & ~scl_d;
  assign scl_fall = ~scl_s[1] & scl_d;
  assign start_ev = scl_s[1] & scl_d & sda_d & ~sda_s[1];
  assign stop_ev  = scl_s[1] & scl_d & ~sda_d & sda_s[1];

  // ----------------------------------------------------------------
  // Link domain: transaction state machine
  // ----------------------------------------------------------------
  link_st_t    st;
  logic [3:0]  bcnt;
  logic [7:0]  shreg, txsh, cmd, wr_data;
  logic [15:0] ptr, wr_addr;
  logic [4:0]  left;
  logic        sda_drv, mack, blk_rd, txcnt, tx_arm, do_wr, reb_tog;
  logic        ack_now, addr_hit, ptr_cfg_ee, rx_dec;
  assign addr_hit   = shreg[7:4] == `SLV_ID && shreg[3] == sel1_s[1] && shreg[2] == sel0_s[1];
  assign ptr_cfg_ee = ptr[15:8] == `CMD_EE_CFG;
  assign rx_dec     = scl_fall && bcnt == 4'h8 && st != L_TX && st != L_IDLE;
  // Acknowledge decision for the byte just received.
  always_comb begin
    ack_now = 1'b0;
    unique case (st)
      L_ADDR:  ack_now = addr_hit & ~busy_s[1];
      L_CMD:   ack_now = shreg <= `REG_LAST ||
                         (shreg >= `CMD_EE_CFG && shreg <= `CMD_BLK_WR) ||
                         shreg == `CMD_REBOOT ||
                         (shreg == `CMD_BLK_RD && !busy_s[1]);
      L_DATA1: ack_now = cmd != `CMD_EE_CFG || shreg <= `REG_LAST;
      L_DATA2, L_BDATA: ack_now = !(ptr_cfg_ee && lock_s[1]);
      L_BCNT:  ack_now = shreg != 8'h00 && shreg <= `BLK_MAX;
      default: ack_now = 1'b0;
    endcase
  end

  // Bit engine and byte decoder; a stop anywhere frees the data line.
  always_ff @(posedge link_clk_i) begin
    if (!lrst_n) begin
      st <= L_IDLE; bcnt <= 4'h0; shreg <= 8'h00; txsh <= 8'h00;
      cmd <= 8'h00; ptr <= 16'h0000; left <= 5'h00; sda_drv <= 1'b0;
      mack <= 1'b0; blk_rd <= 1'b0; txcnt <= 1'b0; tx_arm <= 1'b0;
      do_wr <= 1'b0; wr_addr <= 16'h0000; wr_data <= 8'h00; reb_tog <= 1'b0;
    end else begin
      do_wr <= 1'b0;
      if (stop_ev) begin
        st      <= L_IDLE;
        sda_drv <= 1'b0;
        if (st == L_TX || (st == L_NACK && !mack)) blk_rd <= 1'b0; // Also after a read the master cut short.
      end else if (start_ev) begin
        st      <= L_ADDR;
        bcnt    <= 4'h0;
        sda_drv <= 1'b0;
      end else if (st != L_IDLE && scl_rise) begin
        shreg <= {shreg[6:0], sda_s[1]};
        bcnt  <= bcnt + 4'h1;
        if (bcnt == 4'h8) mack <= ~sda_s[1];
      end else if (st != L_IDLE && scl_fall) begin
        if (bcnt == 4'h8 && st == L_TX) begin
          sda_drv <= 1'b0;
          txcnt   <= 1'b0;
          if (!txcnt) ptr <= blk_rd ? blk_next(ptr) : ptr + 16'h0001;
        end else if (bcnt == 4'h8) begin
          sda_drv <= ack_now;
          if (!ack_now) st <= L_NACK;
          else begin
            unique case (st)
              L_ADDR: begin
                if (shreg[0]) begin
                  st     <= L_TX;
                  tx_arm <= 1'b1;
                  txcnt  <= blk_rd;
                  txsh   <= blk_rd ? `BLK_RD_COUNT : rd_data;
                  left   <= blk_rd ? 5'(`BLK_MAX) : 5'h00;
                end else st <= L_CMD;
              end
              L_CMD: begin
                cmd    <= shreg;
                blk_rd <= shreg == `CMD_BLK_RD;
                if (shreg <= `REG_LAST) ptr <= {8'h00, shreg};
                if (shreg == `CMD_REBOOT) reb_tog <= ~reb_tog;
                if (shreg == `CMD_BLK_WR) st <= L_BCNT;
                else if (shreg <= `CMD_EE_U1 && shreg != `CMD_BLK_RD) st <= L_DATA1;
                else st <= L_NACK;
              end
              L_DATA1: begin
                if (cmd <= `REG_LAST) begin
                  do_wr   <= 1'b1;
                  wr_addr <= {8'h00, cmd};
                  wr_data <= shreg;
                  st      <= L_NACK;
                end else begin
                  ptr <= {cmd, shreg};
                  st  <= L_DATA2;
                end
              end
              L_DATA2: begin
                do_wr   <= 1'b1;
                wr_addr <= ptr;
                wr_data <= shreg;
                st      <= L_NACK;
              end
              L_BCNT: begin
                left <= shreg[4:0];
                st   <= L_BDATA;
              end
              L_BDATA: begin
                do_wr   <= 1'b1;
                wr_addr <= ptr;
                wr_data <= shreg;
                ptr     <= blk_next(ptr);
                left    <= left - 5'h01;
                if (left == 5'h01) st <= L_NACK;
              end
              default: st <= L_NACK;
            endcase
          end
        end else if (bcnt == 4'h9) begin
          bcnt <= 4'h0;
          if (tx_arm) begin
            tx_arm  <= 1'b0;
            sda_drv <= ~txsh[7];
          end else if (st == L_TX && mack && left != 5'h00) begin
            txsh    <= rd_data;
            left    <= left - 5'h01;
            sda_drv <= ~rd_data[7];
          end else begin
            sda_drv <= 1'b0;
            if (st == L_TX) st <= L_NACK;
          end
        end else if (st == L_TX && bcnt != 4'h0) begin
          txsh    <= {txsh[6:0], 1'b0};
          sda_drv <= ~txsh[6];
        end
      end
    end
  end

  assign sda_o      = 1'b0;
  assign sda_oe_n_o = ~sda_drv;

  // ----------------------------------------------------------------
  // Link domain: request channel to the core
  // ----------------------------------------------------------------
  // Toggle handshake; the request word stays still until the core answers.
  mem_req_t    req;
  logic        req_tog, wr_pend, dirty, chan_idle;
  logic [15:0] fptr;
  assign chan_idle = req_tog == ack_s[1];
  always_ff @(posedge link_clk_i) begin
    if (!lrst_n) begin
      req <= '0; req_tog <= 1'b0; wr_pend <= 1'b0; dirty <= 1'b1; fptr <= 16'h0000;
    end else begin
      if (chan_idle && wr_pend) begin
        req     <= '{we: 1'b1, addr: wr_addr, data: wr_data};
        req_tog <= ~req_tog;
        wr_pend <= 1'b0;
      end else if (chan_idle && (dirty || ptr != fptr)) begin
        // Prefetch what the next read byte would return.
        req     <= '{we: 1'b0, addr: ptr, data: 8'h00};
        req_tog <= ~req_tog;
        fptr    <= ptr;
        dirty   <= 1'b0;
      end
      if (do_wr) begin
        wr_pend <= 1'b1;
        dirty   <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Core domain: synchronisers
  // ----------------------------------------------------------------
  logic [2:0] req_s, reb_s;
  logic [1:0] sup_s;
  logic       sup_d, req_new, go;
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      req_s <= 3'h0; reb_s <= 3'h0; sup_s <= 2'h0; sup_d <= 1'b0;
    end else begin
      req_s <= {req_s[1:0], req_tog};
      reb_s <= {reb_s[1:0], reb_tog};
      sup_s <= {sup_s[0], supply_ok_i};
      sup_d <= sup_s[1];
    end
  end
  assign req_new = req_s[2] ^ req_s[1];
  assign go      = (sup_s[1] & ~sup_d) | (reb_s[2] ^ reb_s[1]);
  // ----------------------------------------------------------------
  // Core domain: power-up and reboot load
  // ----------------------------------------------------------------
  load_st_t   ld_st;
  logic [7:0] ld_cnt;
  logic [6:0] ld_idx;
  logic       ld_copy;
  assign ld_copy = ld_st == C_COPY && ld_cnt == 8'h00;
  // A 1 MHz tick divided from the core clock paces the copy.
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      ld_st <= C_IDLE; ld_cnt <= 8'h00; ld_idx <= 7'h00;
    end else begin
      unique case (ld_st)
        C_IDLE: if (go) begin
          ld_st  <= C_DELAY;
          ld_cnt <= 8'(`LOAD_DLY_CYC - 1);
        end
        C_DELAY: if (ld_cnt == 8'h00) begin
          ld_st  <= C_COPY;
          ld_cnt <= 8'(`LOAD_DIV_CYC - 1);
          ld_idx <= 7'h00;
        end else ld_cnt <= ld_cnt - 8'h01;
        C_COPY: if (ld_cnt == 8'h00) begin
          ld_cnt <= 8'(`LOAD_DIV_CYC - 1);
          ld_idx <= ld_idx + 7'h01;
          if (ld_idx == `CFG_BYTES - 7'h01) ld_st <= C_IDLE;
        end else ld_cnt <= ld_cnt - 8'h01;
        default: ld_st <= C_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Core domain: storage
  // ----------------------------------------------------------------
  logic [7:0]  bank   [`CFG_BYTES];
  logic [7:0]  cfg_ee [`CFG_BYTES];
  logic [7:0]  user   [`USER_BYTES];
  logic [19:0] ee_cnt;
  logic [7:0]  rd_mux;
  // Low bytes above 45h in register and configuration EEPROM space read as zero.
  always_comb begin
    rd_mux = 8'h00;
    if (!req.addr[15]) begin
      if (req.addr[7:0] <= `REG_LAST) rd_mux = bank[req.addr[6:0]];
    end else if (req.addr[15:8] == `CMD_EE_CFG) begin
      if (req.addr[7:0] <= `REG_LAST) rd_mux = cfg_ee[req.addr[6:0]];
    end else rd_mux = user[uidx(req.addr)];
  end

  // Arrays are cleared by reset only so that simulation starts defined.
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      bank <= '{default: 8'h00}; cfg_ee <= '{default: 8'h00}; user <= '{default: 8'h00};
      ee_cnt <= 20'h0_0000; rd_data <= 8'h00; ack_tog <= 1'b0;
    end else begin
      if (ee_cnt != 20'h0_0000) ee_cnt <= ee_cnt - 20'h0_0001;
      if (ld_copy) bank[ld_idx] <= cfg_ee[ld_idx];
      if (req_new) begin
        ack_tog <= ~ack_tog;
        if (!req.we) rd_data <= rd_mux;
        else if (!req.addr[15]) begin
          if (req.addr[7:0] <= `REG_LAST) bank[req.addr[6:0]] <= req.data;
        end else begin
          if (req.addr[15:8] != `CMD_EE_CFG) user[uidx(req.addr)] <= req.data;
          else if (req.addr[7:0] <= `REG_LAST) cfg_ee[req.addr[6:0]] <= req.data;
          ee_cnt <= 20'(EE_WR_CYC);
        end
      end
    end
  end

  // Busy covers supply low, the load and an EEPROM write cycle.
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      busy     <= 1'b1;
      lock_bit <= 1'b0;
    end else begin
      busy     <= ld_st != C_IDLE || !sup_s[1] || ee_cnt != 20'h0_0000 || go;
      lock_bit <= bank[`LOCK_REG][`LOCK_BIT];
    end
  end
  assign busy_o = busy;

  for (genvar g = 0; g < `CFG_BYTES; g++) begin : g_out
    assign cfg_bank_o[g*8 +: 8] = bank[g];
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  logic [19:0] ld_age;
  always_ff @(posedge clk_i) begin
    if (!rst_n_i || ld_st == C_IDLE) ld_age <= 20'h0_0000;
    else ld_age <= ld_age + 20'h0_0001;
  end
  sequence s_trig;
    ld_st == C_IDLE && go;
  endsequence
  sequence s_wait;
    ld_st == C_DELAY ##DLY_A ld_st == C_COPY;
  endsequence

  addr_busy_nack_a: assert property (@(posedge link_clk_i) disable iff (!lrst_n)
    rx_dec && st == L_ADDR && busy_s[1] |=> !sda_drv && st == L_NACK)
    else $error("Address acknowledged while busy.");
  reg_range_nack_a: assert property (@(posedge link_clk_i) disable iff (!lrst_n)
    rx_dec && st == L_CMD && shreg > `REG_LAST && shreg < `CMD_EE_CFG |=> !sda_drv)
    else $error("Bad register pointer acknowledged.");
  cfg_low_nack_a: assert property (@(posedge link_clk_i) disable iff (!lrst_n)
    rx_dec && st == L_DATA1 && cmd == `CMD_EE_CFG && shreg > `REG_LAST |=> !sda_drv ##1 !do_wr)
    else $error("Bad configuration EEPROM address acknowledged.");
  blk_rd_busy_a: assert property (@(posedge link_clk_i) disable iff (!lrst_n)
    rx_dec && st == L_CMD && shreg == `CMD_BLK_RD && busy_s[1] |=> !sda_drv)
    else $error("Block read command acknowledged while busy.");
  lock_refuse_a: assert property (@(posedge link_clk_i) disable iff (!lrst_n)
    rx_dec && (st == L_DATA2 || st == L_BDATA) && ptr_cfg_ee && lock_s[1] |=> !do_wr && !sda_drv)
    else $error("Locked configuration EEPROM written.");
  cfg_saturate_a: assert property (@(posedge link_clk_i) disable iff (!lrst_n)
    rx_dec && st == L_BDATA && ack_now && (ptr == `PTR_REG_LAST || ptr == `PTR_EE_LAST)
    |=> do_wr && ptr == $past(ptr))
    else $error("Pointer moved past the last configuration byte.");
  page_wrap_a: assert property (@(posedge link_clk_i) disable iff (!lrst_n)
    rx_dec && st == L_BDATA && ack_now && ptr[7:0] == 8'hff && ptr[15:8] != `CMD_EE_CFG && ptr[15]
    |=> ptr[7:0] == 8'h00 && ptr[15:8] == $past(ptr[15:8]))
    else $error("User page did not wrap.");
  rd_incr_a: assert property (@(posedge link_clk_i) disable iff (!lrst_n)
    scl_fall && bcnt == 4'h8 && st == L_TX && !txcnt && !blk_rd |=> ptr == $past(ptr) + 16'h0001)
    else $error("Receive byte did not advance the pointer.");
  load_delay_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    s_trig |=> s_wait)
    else $error("Load did not start after the power-up delay.");
  load_time_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    ld_age <= 20'(LOAD_MAX_CYC) && (ld_st == C_IDLE || busy_o))
    else $error("Load too long or access not blocked.");
  ee_cycle_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    req_new && req.we && req.addr[15] |=> ee_cnt == 20'(EE_WR_CYC) ##1 busy_o)
    else $error("EEPROM write cycle not started.");
endmodule : smbus_config_eeprom_access

// >>> test/smbus_master_model.sv
// Bus master model that drives the serial clock and data the way a microcontroller does.
// Assumes that the bench resolves the pulled-up data wire from all drivers and feeds it back.
`timescale 1ns/100ps
module smbus_master_model (
  input  wire logic clk_i,
  input  wire logic sda_i,
  output logic      scl_o,
  output logic      sda_low_o
);
  // The bus idles with both lines released high.
  initial begin
    scl_o     = 1'b1;
    sda_low_o = 1'b0;
  end
  // A half clock period of 16 core cycles is 8 link clocks, above the 6 link clocks that the slave needs.
  task hp;
    repeat (16) @(negedge clk_i);
  endtask : hp
  // Data moves 8 cycles after the clock falls, so the slave never sees it change while SCL is high.
  task bit_io(input logic b, output logic r);
    sda_low_o = ~b;
    hp();
    scl_o = 1'b1;
    hp();
    r = sda_i;
    scl_o = 1'b0;
    repeat (8) @(negedge clk_i);
  endtask : bit_io
  // Start and repeated start: the data line falls while the clock is high.
  task start;
    sda_low_o = 1'b0;
    hp();
    scl_o = 1'b1;
    hp();
    sda_low_o = 1'b1;
    hp();
    scl_o = 1'b0;
    repeat (8) @(negedge clk_i);
  endtask : start
  // Stop: the data line rises while the clock is high.
  task stop;
    sda_low_o = 1'b1;
    hp();
    scl_o = 1'b1;
    hp();
    sda_low_o = 1'b0;
    hp();
  endtask : stop
  task wr(input logic [7:0] b, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(b[i], r);
    bit_io(1'b1, r);
    ack = ~r;
  endtask : wr
  // The master acknowledges a byte or ends the read with NACK, as the caller asks.
  task rd(input logic mack, output logic [7:0] b);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, r);
      b[i] = r;
    end
    bit_io(~mack, r);
  endtask : rd
endmodule : smbus_master_model

// >>> test/smbus_config_eeprom_access_test.sv
// Self-checking bench for the SMBus configuration and EEPROM access block.
// Assumes the master model of test/ and shortened EEPROM write and load limits.
`timescale 1ns/100ps
module smbus_config_eeprom_access_test;
  import smbus_access_pkg::*;
  typedef struct packed {logic [7:0] cmd; logic [7:0] data; logic a_cmd; logic a_data;} row_t;
  logic clk_i = 1'b0, link_clk_i = 1'b0, rst_n_i = 1'b0, supply_ok_i = 1'b0;
  logic scl, m_low, sda, sda_o, sda_oe_n_o, busy_o, a;
  logic [8*70-1:0] cfg_bank_o;
  logic [7:0] b;
  int n_fail = 0, n_compared = 0;
  row_t rows [7] = '{'{8'h10, 8'hAB, 1'b1, 1'b1}, '{8'h00, 8'h3C, 1'b1, 1'b1}, '{8'h45, 8'hF0, 1'b1, 1'b1},
                     '{8'h46, 8'h11, 1'b0, 1'b0}, '{8'h50, 8'h22, 1'b0, 1'b0}, '{8'h80, 8'h46, 1'b1, 1'b0},
                     '{8'h81, 8'hFF, 1'b1, 1'b1}};
  always #20 clk_i = ~clk_i;
  // The link clock is offset so that its edges never line up with the core clock.
  initial begin
    #7;
    forever #40 link_clk_i = ~link_clk_i;
  end
  // Pull-up wire: low whenever the master or the slave pulls it.
  assign sda = m_low ? 1'b0 : (sda_oe_n_o ? 1'b1 : sda_o);
  smbus_config_eeprom_access #(.EE_WR_CYC(200), .LOAD_MAX_CYC(1900)) uut (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .link_clk_i(link_clk_i), .scl_i(scl), .sda_i(sda),
    .sda_o(sda_o), .sda_oe_n_o(sda_oe_n_o), .addr_select_low_i(1'b0), .addr_select_high_i(1'b1),
    .supply_ok_i(supply_ok_i), .busy_o(busy_o), .cfg_bank_o(cfg_bank_o));
  smbus_master_model m (.clk_i(clk_i), .sda_i(sda), .scl_o(scl), .sda_low_o(m_low));
  task chk_ack(input string what, input logic exp, input logic got);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD %s expected %b seen %b", what, exp, got);
    end
  endtask : chk_ack
  task chk_byte(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : chk_byte
  task xw(input logic [7:0] v, input logic exp);
    m.wr(v, a);
    chk_ack("byte ack", exp, a);
  endtask : xw
  task xr(input logic mack, input logic [7:0] exp);
    m.rd(mack, b);
    chk_byte("read byte", exp, b);
  endtask : xr
  task results;
    $display("Counts: %0d compared, %0d mismatched", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : results
  // Bounded wait for the end of a load; a hang counts as a mismatch and ends the run.
  task wait_idle;
    for (int k = 0; k < 6000 && busy_o !== 1'b0; k++) @(negedge clk_i);
    if (busy_o !== 1'b0) begin
      n_fail++;
      $display("BAD busy_o expected 0 seen %b", busy_o);
      results();
    end
    repeat (4) @(negedge link_clk_i);
  endtask : wait_idle
  task send(input logic [7:0] c);
    m.start();
    xw(8'hA8, 1'b1);
    xw(c, 1'b1);
    m.stop();
  endtask : send
  // Write byte: address, command and one data byte, all acknowledged.
  task wbyte(input logic [7:0] c, input logic [7:0] d);
    m.start();
    xw(8'hA8, 1'b1);
    xw(c, 1'b1);
    xw(d, 1'b1);
    m.stop();
  endtask : wbyte
  initial begin
    repeat (12) @(negedge clk_i);
    chk_ack("busy_o in reset", 1'b1, busy_o);
    chk_byte("bank in reset", 8'h00, cfg_bank_o[8*16+:8]);
    rst_n_i = 1'b1;
    supply_ok_i = 1'b1;
    repeat (10) @(negedge clk_i);
    m.start();
    xw(8'hA8, 1'b0);
    m.stop();
    wait_idle();
    $display("test reset and load done");
    // Ordinary write byte cases: register writes, refused commands and pointer presets.
    foreach (rows[i]) begin
      m.start();
      xw(8'hA8, 1'b1);
      xw(rows[i].cmd, rows[i].a_cmd);
      xw(rows[i].data, rows[i].a_data);
      m.stop();
      repeat (40) @(negedge clk_i);
      if (rows[i].cmd < 8'h46) chk_byte("bank byte", rows[i].data, cfg_bank_o[rows[i].cmd*8+:8]);
    end
    $display("test write byte table done");
    // Foreign select pins are refused; the don't-care address bit is ignored.
    m.start();
    xw(8'hA0, 1'b0);
    m.start();
    xw(8'hAA, 1'b1);
    m.stop();
    send(8'h10);
    for (int i = 0; i < 2; i++) begin
      m.start();
      xw(8'hA9, 1'b1);
      xr(1'b0, i == 0 ? 8'hAB : 8'h00);
      m.stop();
    end
    $display("test address and receive done");
    // User EEPROM write word and its busy cycle, the lock, then page wrap in block write and block read.
    m.start();
    xw(8'hA8, 1'b1);
    xw(8'h82, 1'b1);
    xw(8'hFF, 1'b1);
    xw(8'h5A, 1'b1);
    m.stop();
    chk_ack("busy_o in write cycle", 1'b1, busy_o);
    wait_idle();
    m.start();
    xw(8'hA9, 1'b1);
    xr(1'b0, 8'h5A);
    m.stop();
    wbyte(8'h45, 8'h01);
    m.start();
    xw(8'hA8, 1'b1);
    xw(8'h80, 1'b1);
    xw(8'h00, 1'b1);
    xw(8'h77, 1'b0);
    m.stop();
    wbyte(8'h82, 8'hFF);
    m.start();
    xw(8'hA8, 1'b1);
    xw(8'h83, 1'b1);
    xw(8'h02, 1'b1);
    xw(8'h11, 1'b1);
    xw(8'h22, 1'b1);
    m.stop();
    wait_idle();
    wbyte(8'h82, 8'hFF);
    m.start();
    xw(8'hA8, 1'b1);
    xw(8'h84, 1'b1);
    m.start();
    xw(8'hA9, 1'b1);
    xr(1'b1, 8'h10);
    xr(1'b1, 8'h11);
    xr(1'b0, 8'h22);
    m.stop();
    $display("test user EEPROM done");
    // Block write of four bytes from 43h must pile the surplus into 45h.
    send(8'h43);
    m.start();
    xw(8'hA8, 1'b1);
    xw(8'h83, 1'b1);
    xw(8'h04, 1'b1);
    for (int i = 1; i <= 4; i++) xw(i[7:0], 1'b1);
    m.stop();
    repeat (40) @(negedge clk_i);
    chk_byte("reg 43h", 8'h01, cfg_bank_o[8*67+:8]);
    chk_byte("reg 44h", 8'h02, cfg_bank_o[8*68+:8]);
    chk_byte("reg 45h", 8'h04, cfg_bank_o[8*69+:8]);
    $display("test block write done");
    // Block read cut short by a master NACK; the slave must let go of the line.
    send(8'h43);
    m.start();
    xw(8'hA8, 1'b1);
    xw(8'h84, 1'b1);
    m.start();
    xw(8'hA9, 1'b1);
    xr(1'b1, 8'h10);
    xr(1'b1, 8'h01);
    xr(1'b0, 8'h02);
    m.stop();
    chk_ack("sda released", 1'b1, sda_oe_n_o);
    $display("test block read done");
    // Reboot: address refused while loading, then the bank returns to the EEPROM copy.
    send(8'h88);
    m.start();
    xw(8'hA8, 1'b0);
    m.stop();
    wait_idle();
    chk_byte("reg 10h reloaded", 8'h00, cfg_bank_o[8*16+:8]);
    $display("test reboot done");
    results();
  end
endmodule : smbus_config_eeprom_access_test
